// file: hdl/dbp_pkg.sv
package dbp_pkg;

  // Core clock
  localparam int unsigned CLK_HZ      = 125_000_000;

  // Protocol clock ceilings
  localparam int unsigned JTAG_MAX_HZ = 10_000_000;
  localparam int unsigned TWO_MAX_HZ  = 3_000_000;
  localparam int unsigned HALF_W      = 16;

  // Least half period in core cycles, rounded up so the rate never exceeds
  localparam logic [HALF_W-1:0] JTAG_HALF_MIN =
    HALF_W'((CLK_HZ + 2 * JTAG_MAX_HZ - 1) / (2 * JTAG_MAX_HZ));
  localparam logic [HALF_W-1:0] TWO_HALF_MIN =
    HALF_W'((CLK_HZ + 2 * TWO_MAX_HZ - 1) / (2 * TWO_MAX_HZ));

  // Target supply setting, units of 0.1 V
  localparam int unsigned VCC_W = 6;
  localparam logic [VCC_W-1:0] VCC_MIN_DV = 6'h12;
  localparam logic [VCC_W-1:0] VCC_MAX_DV = 6'h24;
  localparam logic [VCC_W-1:0] VCC_RST_DV = 6'h21;

  // Overcurrent comparator threshold, mA
  localparam logic [7:0] OC_LIMIT_MA = 8'hA0;

  // Cycles spent in the parked state between two modes
  localparam logic [3:0] PARK_CYC = 4'h8;

  // LED blink half period
  localparam int unsigned BLINK_MS  = 100;
  localparam int unsigned BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;

  typedef enum logic [1:0] {
    DBP_MODE_OFF,
    DBP_MODE_JTAG,
    DBP_MODE_TWO
  } dbp_mode_t;

  // One bit per connector signal pin
  typedef struct packed {
    logic tdo;
    logic tdi;
    logic tms;
    logic tck;
    logic test;
    logic rst;
  } dbp_pins_t;

  // Levels the host wants on the JTAG control pins
  typedef struct packed {
    logic tdi;
    logic tms;
    logic test;
    logic rst;
  } dbp_jtag_t;

  typedef struct packed {
    logic pwr;
    logic mode;
  } dbp_led_t;

  // Larger of two half periods
  function automatic logic [HALF_W-1:0] dbp_max_half(
    input logic [HALF_W-1:0] a,
    input logic [HALF_W-1:0] b
  );
    return (a > b) ? a : b;
  endfunction

endpackage

// file: hdl/dbp_clkgen.sv
`timescale 1ns/1ps
module dbp_clkgen #(
  parameter int unsigned HALF_W = 16
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic              run,
  input  wire logic [HALF_W-1:0] half_req,
  input  wire logic [HALF_W-1:0] half_min,
  output logic                   clk_lvl_r,
  output logic                   rise_en_r,
  output logic                   fall_en_r,
  output logic [HALF_W-1:0]      half_eff_r
);
  import dbp_pkg::*;

  logic [HALF_W-1:0] cnt_r;
  logic [HALF_W-1:0] half_nxt;

  // Slowest of request and ceiling wins
  assign half_nxt = dbp_max_half(half_req, half_min);

  // Effective half period, latched only while stopped
  always_ff @(posedge clock) begin
    if (!rstn) begin
      half_eff_r <= half_min;
    end else if (!run) begin
      half_eff_r <= half_nxt;
    end
  end

  // Divider and edge enables
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_r     <= '0;
      clk_lvl_r <= 1'b0;
      rise_en_r <= 1'b0;
      fall_en_r <= 1'b0;
    end else if (!run) begin
      cnt_r     <= '0;
      clk_lvl_r <= 1'b0;
      rise_en_r <= 1'b0;
      fall_en_r <= 1'b0;
    end else if (cnt_r + 1'b1 >= half_eff_r) begin
      cnt_r     <= '0;
      clk_lvl_r <= ~clk_lvl_r;
      rise_en_r <= ~clk_lvl_r;
      fall_en_r <= clk_lvl_r;
    end else begin
      cnt_r     <= cnt_r + 1'b1;
      rise_en_r <= 1'b0;
      fall_en_r <= 1'b0;
    end
  end

endmodule

// file: hdl/dbp_led.sv
`timescale 1ns/1ps
module dbp_led #(
  parameter int unsigned BLINK = 12_500_000
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        ready,
  input  wire logic        waiting,
  input  wire logic        xfer,
  input  wire logic        fw_update,
  input  wire logic        error,
  output dbp_pkg::dbp_led_t led_r
);
  import dbp_pkg::*;

  logic [31:0] tick_r;
  logic [1:0]  phase_r;

  // Slow phase counter, one step per blink half period
  always_ff @(posedge clock) begin
    if (!rstn) begin
      tick_r  <= '0;
      phase_r <= '0;
    end else if (tick_r >= 32'(BLINK - 1)) begin
      tick_r  <= '0;
      phase_r <= phase_r + 1'b1;
    end else begin
      tick_r  <= tick_r + 1'b1;
    end
  end

  // Indication priority: error, update, offline, transfer
  always_ff @(posedge clock) begin
    if (!rstn) begin
      led_r <= '0;
    end else if (error) begin
      led_r.pwr  <= 1'b0;
      led_r.mode <= (phase_r == 2'h0);
    end else if (fw_update) begin
      led_r.pwr  <= phase_r[0];
      led_r.mode <= phase_r[0];
    end else if (!ready) begin
      led_r <= '0;
    end else begin
      led_r.pwr  <= 1'b1;
      led_r.mode <= xfer ? phase_r[0] : waiting;
    end
  end

endmodule

// file: hdl/dbp_port.sv
`timescale 1ns/1ps
// Function
// - The JTAG test clock never runs faster than 10 MHz whatever software asks.
// - The two-wire clock never runs faster than 3 MHz whatever software asks.
// - Software sets target supply from 1.8 V to 3.6 V in 0.1 V steps.
// - Target supply overcurrent at 160 mA latches the error state.
// - After power-up data, mode and clock pins float pulled to 3.3 V, test low, reset high.
// - In JTAG mode TDO is input and TDI, TMS, TCK, test and reset are driven.
// - In two-wire mode TDO is bidirectional data, TCK the clock, others float, reset low.
// - With no error or firmware update, both LEDs are off when not connected to the host or not ready.
// - The mode LED flashes during a data transfer in a debug session.
// - On error the power LED is off and the mode LED shows an error pattern until power cycle.
// - Unless in error, both LEDs blink during a firmware update, and the host keeps the link meanwhile.
module dbp_port #(
  parameter int unsigned BLINK_CYCLES = dbp_pkg::BLINK_CYC
) (
  input  wire logic                           clock,
  input  wire logic                           rstn,
  input  wire logic                           host_ready,
  input  wire logic                           fw_update,
  input  wire logic                           xfer_active,
  input  wire dbp_pkg::dbp_mode_t             mode_req,
  input  wire logic [dbp_pkg::HALF_W-1:0]     half_req,
  input  wire logic [dbp_pkg::VCC_W-1:0]      vcc_req,
  input  wire logic                           vcc_wr,
  input  wire dbp_pkg::dbp_jtag_t             jtag_req,
  input  wire logic                           two_wire_dout,
  input  wire logic                           two_wire_doe,
  input  wire logic                           tdo_pin,
  input  wire logic                           oc_pin,
  output dbp_pkg::dbp_pins_t                  pin_out_r,
  output dbp_pkg::dbp_pins_t                  pin_oe_r,
  output logic                                pull_vcc_r,
  output logic                                vcc_en_r,
  output logic [dbp_pkg::VCC_W-1:0]           vcc_dv_r,
  output logic [7:0]                          oc_limit_r,
  output dbp_pkg::dbp_mode_t                  mode_act_r,
  output logic [dbp_pkg::HALF_W-1:0]          half_eff_r,
  output logic                                tdo_bit_r,
  output logic                                tdo_valid_r,
  output logic                                error_r,
  output dbp_pkg::dbp_led_t                   led_r
);
  import dbp_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PARK,
    ST_JTAG,
    ST_TWO
  } dbp_state_t;

  dbp_state_t        state_r;
  dbp_state_t        state_nxt;
  logic [3:0]        park_r;
  logic              tdo_s1_r;
  logic              tdo_s2_r;
  logic              oc_s1_r;
  logic              oc_s2_r;
  logic              clk_run;
  logic [HALF_W-1:0] half_min;
  logic              clk_lvl;
  logic              rise_en;
  logic              fall_en;
  logic              waiting;
  logic              xfer;

  // Pin inputs cross into the core clock through two flops
  always_ff @(posedge clock) begin
    if (!rstn) begin
      tdo_s1_r <= 1'b1;
      tdo_s2_r <= 1'b1;
      oc_s1_r  <= 1'b0;
      oc_s2_r  <= 1'b0;
    end else begin
      tdo_s1_r <= tdo_pin;
      tdo_s2_r <= tdo_s1_r;
      oc_s1_r  <= oc_pin;
      oc_s2_r  <= oc_s1_r;
    end
  end

  // Overcurrent latches until the probe is reset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      error_r <= 1'b0;
    end else if (oc_s2_r) begin
      error_r <= 1'b1;
    end
  end

  // Comparator threshold fed to the supply monitor
  always_ff @(posedge clock) begin
    if (!rstn) begin
      oc_limit_r <= OC_LIMIT_MA;
    end else begin
      oc_limit_r <= OC_LIMIT_MA;
    end
  end

  // Target supply setting, out of range writes ignored
  always_ff @(posedge clock) begin
    if (!rstn) begin
      vcc_dv_r <= VCC_RST_DV;
    end else if (vcc_wr && vcc_req >= VCC_MIN_DV
                 && vcc_req <= VCC_MAX_DV) begin
      vcc_dv_r <= vcc_req;
    end
  end

  // Supply drops once an error is latched
  always_ff @(posedge clock) begin
    if (!rstn) begin
      vcc_en_r <= 1'b0;
    end else begin
      vcc_en_r <= host_ready && !error_r;
    end
  end

  // Mode sequencing: leave a mode only through the parked state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (!error_r && host_ready && !fw_update) begin
          if (mode_req == DBP_MODE_JTAG) begin
            state_nxt = ST_JTAG;
          end else if (mode_req == DBP_MODE_TWO) begin
            state_nxt = ST_TWO;
          end
        end
      end
      ST_JTAG: begin
        if (error_r || !host_ready || fw_update
            || mode_req != DBP_MODE_JTAG) begin
          state_nxt = ST_PARK;
        end
      end
      ST_TWO: begin
        if (error_r || !host_ready || fw_update
            || mode_req != DBP_MODE_TWO) begin
          state_nxt = ST_PARK;
        end
      end
      ST_PARK: begin
        if (park_r >= PARK_CYC - 1'b1) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Park timer
  always_ff @(posedge clock) begin
    if (!rstn) begin
      park_r <= '0;
    end else if (state_r == ST_PARK) begin
      park_r <= park_r + 1'b1;
    end else begin
      park_r <= '0;
    end
  end

  // Reported active mode
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mode_act_r <= DBP_MODE_OFF;
    end else begin
      case (state_nxt)
        ST_JTAG: mode_act_r <= DBP_MODE_JTAG;
        ST_TWO:  mode_act_r <= DBP_MODE_TWO;
        default: mode_act_r <= DBP_MODE_OFF;
      endcase
    end
  end

  // Ceiling follows the mode about to run
  assign clk_run  = (state_r == ST_JTAG) || (state_r == ST_TWO);
  assign half_min = (state_nxt == ST_TWO) ? TWO_HALF_MIN
                                          : JTAG_HALF_MIN;

  dbp_clkgen #(
    .HALF_W (HALF_W)
  ) u_clkgen (
    .clock      (clock),
    .rstn       (rstn),
    .run        (clk_run),
    .half_req   (half_req),
    .half_min   (half_min),
    .clk_lvl_r  (clk_lvl),
    .rise_en_r  (rise_en),
    .fall_en_r  (fall_en),
    .half_eff_r (half_eff_r)
  );

  // Connector pin drivers per mode
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pin_out_r      <= '0;
      pin_oe_r       <= '0;
      pin_out_r.rst  <= 1'b1;
      pin_oe_r.rst   <= 1'b1;
      pin_oe_r.test  <= 1'b1;
      pull_vcc_r     <= 1'b0;
    end else begin
      case (state_r)
        ST_JTAG: begin
          pin_out_r.tdo  <= 1'b0;
          pin_oe_r.tdo   <= 1'b0;
          pin_out_r.tdi  <= jtag_req.tdi;
          pin_out_r.tms  <= jtag_req.tms;
          pin_out_r.tck  <= clk_lvl;
          pin_out_r.test <= jtag_req.test;
          pin_out_r.rst  <= jtag_req.rst;
          pin_oe_r.tdi   <= 1'b1;
          pin_oe_r.tms   <= 1'b1;
          pin_oe_r.tck   <= 1'b1;
          pin_oe_r.test  <= 1'b1;
          pin_oe_r.rst   <= 1'b1;
          pull_vcc_r     <= 1'b0;
        end
        ST_TWO: begin
          pin_out_r.tdo  <= two_wire_dout;
          pin_oe_r.tdo   <= two_wire_doe;
          pin_out_r.tdi  <= 1'b0;
          pin_out_r.tms  <= 1'b0;
          pin_out_r.tck  <= clk_lvl;
          pin_out_r.test <= 1'b0;
          pin_out_r.rst  <= 1'b0;
          pin_oe_r.tdi   <= 1'b0;
          pin_oe_r.tms   <= 1'b0;
          pin_oe_r.tck   <= 1'b1;
          pin_oe_r.test  <= 1'b0;
          pin_oe_r.rst   <= 1'b1;
          pull_vcc_r     <= 1'b1;
        end
        default: begin
          pin_out_r      <= '0;
          pin_oe_r       <= '0;
          pin_out_r.rst  <= 1'b1;
          pin_oe_r.rst   <= 1'b1;
          pin_oe_r.test  <= 1'b1;
          pull_vcc_r     <= 1'b0;
        end
      endcase
    end
  end

  // Target data sampled on the protocol clock rising edge
  always_ff @(posedge clock) begin
    if (!rstn) begin
      tdo_bit_r   <= 1'b0;
      tdo_valid_r <= 1'b0;
    end else if (clk_run && rise_en
                 && !(state_r == ST_TWO && two_wire_doe)) begin
      tdo_bit_r   <= tdo_s2_r;
      tdo_valid_r <= 1'b1;
    end else begin
      tdo_valid_r <= 1'b0;
    end
  end

  // LED status inputs
  assign waiting = clk_run;
  assign xfer    = clk_run && xfer_active;

  dbp_led #(
    .BLINK (BLINK_CYCLES)
  ) u_led (
    .clock     (clock),
    .rstn      (rstn),
    .ready     (host_ready),
    .waiting   (waiting),
    .xfer      (xfer),
    .fw_update (fw_update),
    .error     (error_r),
    .led_r     (led_r)
  );

endmodule

// file: testbench/dbp_port_assertions.sv
`timescale 1ns/1ps
// Protocol checks on the port block outputs
module dbp_port_chk (
  input wire logic                     clock,
  input wire logic                     rstn,
  input wire logic                     host_ready,
  input wire logic                     fw_update,
  input wire logic                     oc_pin,
  input wire logic                     vcc_wr,
  input wire logic [dbp_pkg::VCC_W-1:0] vcc_req,
  input wire dbp_pkg::dbp_pins_t       pin_out_r,
  input wire dbp_pkg::dbp_pins_t       pin_oe_r,
  input wire logic                     pull_vcc_r,
  input wire logic [dbp_pkg::VCC_W-1:0] vcc_dv_r,
  input wire dbp_pkg::dbp_mode_t       mode_act_r,
  input wire logic [dbp_pkg::HALF_W-1:0] half_eff_r,
  input wire logic                     error_r,
  input wire dbp_pkg::dbp_led_t        led_r
);
  import dbp_pkg::*;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // Mode held long enough for the pins to follow, or a mode just left
  sequence s_jtag;
    (mode_act_r == DBP_MODE_JTAG) [*2];
  endsequence
  sequence s_two;
    (mode_act_r == DBP_MODE_TWO) [*2];
  endsequence
  sequence s_leave;
    (mode_act_r != DBP_MODE_OFF) ##1 (mode_act_r == DBP_MODE_OFF);
  endsequence
  // Pin, rate, supply, error and LED relations
  a_reset_pins: assert property (!$past(rstn) |-> pin_oe_r == 6'h03
    && pin_out_r.rst && !pin_out_r.test && !pull_vcc_r)
    else $error("pins not parked after reset");
  a_jtag_pins: assert property (s_jtag |-> pin_oe_r == 6'h1F)
    else $error("jtag pin directions wrong");
  a_two_pins: assert property (s_two |-> !pin_oe_r.tdi
    && !pin_oe_r.tms && !pin_oe_r.test && pin_oe_r.tck && pin_oe_r.rst
    && !pin_out_r.rst && pull_vcc_r)
    else $error("two-wire pin states wrong");
  a_park_pins: assert property (s_leave |=> pin_oe_r == 6'h03)
    else $error("pins not parked between modes");
  a_jtag_rate: assert property (mode_act_r == DBP_MODE_JTAG
    |-> half_eff_r >= JTAG_HALF_MIN)
    else $error("jtag clock too fast");
  a_two_rate: assert property (mode_act_r == DBP_MODE_TWO
    |-> half_eff_r >= TWO_HALF_MIN)
    else $error("two-wire clock too fast");
  a_oc_latch: assert property (oc_pin |-> ##3 error_r)
    else $error("overcurrent not latched");
  a_error_leds: assert property ((error_r) [*2] |-> !led_r.pwr)
    else $error("power led lit on error");
  a_leds_dark: assert property (!host_ready && !fw_update && !error_r
    |=> led_r == 2'b00 || error_r)
    else $error("leds lit without host");
  a_vcc_take: assert property (vcc_wr && vcc_req >= VCC_MIN_DV
    && vcc_req <= VCC_MAX_DV |=> vcc_dv_r == $past(vcc_req))
    else $error("supply setting not taken");
endmodule

bind dbp_port dbp_port_chk dbp_port_chk_i (
  .clock, .rstn, .host_ready, .fw_update, .oc_pin, .vcc_wr, .vcc_req,
  .pin_out_r, .pin_oe_r, .pull_vcc_r, .vcc_dv_r, .mode_act_r,
  .half_eff_r, .error_r, .led_r
);

// file: testbench/dbp_target.sv
`timescale 1ns/1ps
// Target end of the connector: answers on the data pin
module dbp_target (
  input  wire dbp_pkg::dbp_pins_t pin_out_r,
  input  wire dbp_pkg::dbp_pins_t pin_oe_r,
  output logic                    tdo_pin
);
  import dbp_pkg::*;
  logic [7:0] pat_r = 8'hA5;
  logic       exp_q[$];
  wire        act = pin_oe_r.tck & pin_oe_r.rst;
  // Probe first, then target, else the pull-up
  assign tdo_pin = pin_oe_r.tdo ? pin_out_r.tdo : (act ? pat_r[7] : 1'b1);
  // Note the bit shown at each clock rise while the probe is not driving the data pin
  always @(posedge pin_out_r.tck) begin
    if (act && !pin_oe_r.tdo) begin
      exp_q.push_back(pat_r[7]);
    end
  end
  // Next bit after the falling edge
  always @(negedge pin_out_r.tck) begin
    if (act) begin
      pat_r <= {pat_r[6:0], pat_r[7]};
    end
  end
  // Forget notes once the port goes idle
  always @(negedge act) begin
    exp_q.delete();
  end
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dbp_pkg::*;
  logic clock = 1'b0, rstn = 1'b0, host_ready = 1'b0, fw_update = 1'b0;
  logic xfer_active = 1'b0, vcc_wr = 1'b0, oc_pin = 1'b0;
  logic two_wire_dout = 1'b0, two_wire_doe = 1'b0;
  dbp_mode_t mode_req = DBP_MODE_OFF;
  logic [HALF_W-1:0] half_req = 16'h0008;
  logic [VCC_W-1:0] vcc_req = 6'h00;
  dbp_jtag_t jtag_req = 4'h0;
  logic tdo_pin, pull_vcc_r, vcc_en_r, tdo_bit_r, tdo_valid_r, error_r;
  dbp_pins_t pin_out_r, pin_oe_r;
  logic [VCC_W-1:0] vcc_dv_r, vcc_prev, vcc_q[$];
  logic [7:0] oc_limit_r;
  dbp_mode_t mode_act_r;
  logic [HALF_W-1:0] half_eff_r;
  dbp_led_t led_r, on, off;
  logic [5:0] vt[5] = '{6'h11, 6'h12, 6'h25, 6'h24, 6'h00};
  logic [31:0] seed = 32'h2FAD;
  int bad_count = 0, total_checks = 0, i, n, parked;

  dbp_port #(.BLINK_CYCLES(8)) dbp_port_i (.clock, .rstn, .host_ready,
    .fw_update, .xfer_active, .mode_req, .half_req, .vcc_req, .vcc_wr,
    .jtag_req, .two_wire_dout, .two_wire_doe, .tdo_pin, .oc_pin,
    .pin_out_r, .pin_oe_r, .pull_vcc_r, .vcc_en_r, .vcc_dv_r, .oc_limit_r,
    .mode_act_r, .half_eff_r, .tdo_bit_r, .tdo_valid_r, .error_r, .led_r);
  dbp_target dbp_target_i (.pin_out_r, .pin_oe_r, .tdo_pin);

  // Core clock, 8 ns
  initial forever #4 clock = ~clock;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("Checks made %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Bounded wait for a mode, counting parked cycles
  task automatic wait_mode(input dbp_mode_t m);
    n = 0;
    while (mode_act_r !== m) begin
      if (pin_oe_r === 6'h03) parked++;
      if (++n > 300) begin
        chk("mode_act_r", 16'(m), 16'(mode_act_r));
        report_and_stop();
      end
      tick(1);
    end
  endtask
  // Cycles until the protocol clock pin changes
  task automatic wait_tck;
    logic t;
    t = pin_out_r.tck;
    n = 0;
    while (pin_out_r.tck === t) begin
      if (++n > 100) begin
        chk("tck change", 16'h0000, 16'h0001);
        report_and_stop();
      end
      tick(1);
    end
  endtask
  // Levels each LED took over 64 cycles
  task automatic led_scan;
    on = 2'b00;
    off = 2'b00;
    repeat (64) begin
      tick(1);
      on |= led_r;
      off |= ~led_r;
    end
  endtask

  // Supply setting results, oldest note first
  always @(posedge clock) begin
    #2;
    if (rstn && vcc_dv_r !== vcc_prev) begin
      if (vcc_q.size() == 0) chk("vcc_dv_r", 16'(vcc_prev), 16'(vcc_dv_r));
      else chk("vcc_dv_r", 16'(vcc_q.pop_front()), 16'(vcc_dv_r));
    end
    vcc_prev = vcc_dv_r;
  end
  // Sampled target data against the target's notes
  always @(posedge clock) begin
    #2;
    if (tdo_valid_r === 1'b1 && dbp_target_i.exp_q.size() > 0)
      chk("tdo_bit_r", 16'(dbp_target_i.exp_q.pop_front()), 16'(tdo_bit_r));
  end

  // Main sequence
  initial begin
    tick(6);
    rstn = 1'b1;
    tick(1);
    chk("pin_oe_r", 16'h0003, 16'(pin_oe_r));
    chk("rst test out", 16'h0002, 16'({pin_out_r.rst, pin_out_r.test}));
    chk("led_r", 16'h0000, 16'(led_r));
    chk("vcc_dv_r", 16'(VCC_RST_DV), 16'(vcc_dv_r));
    chk("oc_limit_r", 16'h00A0, 16'(oc_limit_r));
    for (i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      vcc_req = (i == 4) ? 6'h12 + 6'(seed[3:0]) : vt[i];
      if (vcc_req >= VCC_MIN_DV && vcc_req <= VCC_MAX_DV)
        vcc_q.push_back(vcc_req);
      vcc_wr = 1'b1;
      tick(1);
      vcc_wr = 1'b0;
      tick(2);
    end
    $display("Test supply done");
    jtag_req = seed[7:4];
    host_ready = 1'b1;
    xfer_active = 1'b1;
    mode_req = DBP_MODE_JTAG;
    wait_mode(DBP_MODE_JTAG);
    tick(2);
    chk("pin_oe_r", 16'h001F, 16'(pin_oe_r));
    chk("jtag levels", 16'(jtag_req), 16'({pin_out_r.tdi, pin_out_r.tms,
      pin_out_r.test, pin_out_r.rst}));
    wait_tck();
    wait_tck();
    chk("jtag half", 16'h0008, 16'(n));
    led_scan();
    chk("leds on", 16'h000D, 16'({on, off}));
    $display("Test jtag done");
    half_req = 16'h0003;
    mode_req = DBP_MODE_TWO;
    parked = 0;
    wait_mode(DBP_MODE_TWO);
    chk("parked", 16'h0001, 16'(parked >= PARK_CYC));
    tick(2);
    chk("pin_oe_r", 16'h0005, 16'(pin_oe_r));
    chk("rst pull", 16'h0001, 16'({pin_out_r.rst, pull_vcc_r}));
    wait_tck();
    wait_tck();
    chk("two half", 16'(TWO_HALF_MIN), 16'(n));
    two_wire_dout = seed[0];
    two_wire_doe = 1'b1;
    tick(3);
    chk("data out", 16'({1'b1, seed[0]}), 16'({pin_oe_r.tdo, pin_out_r.tdo}));
    two_wire_doe = 1'b0;
    $display("Test two-wire done");
    fw_update = 1'b1;
    tick(4);
    chk("pin_oe_r", 16'h0003, 16'(pin_oe_r));
    led_scan();
    chk("leds blink", 16'h000F, 16'({on, off}));
    fw_update = 1'b0;
    host_ready = 1'b0;
    tick(2);
    led_scan();
    chk("leds dark", 16'h0003, 16'({on, off}));
    $display("Test leds done");
    host_ready = 1'b1;
    mode_req = DBP_MODE_JTAG;
    wait_mode(DBP_MODE_JTAG);
    oc_pin = 1'b1;
    tick(1);
    oc_pin = 1'b0;
    tick(3);
    chk("error_r", 16'h0001, 16'(error_r));
    tick(3);
    chk("pins vcc mode", 16'h0018, 16'({pin_oe_r, vcc_en_r, mode_act_r}));
    led_scan();
    chk("error leds", 16'h0007, 16'({on, off}));
    rstn = 1'b0;
    tick(6);
    rstn = 1'b1;
    tick(1);
    chk("error_r", 16'h0000, 16'(error_r));
    $display("Test error done");
    report_and_stop();
  end
endmodule
